// ---- src/pss_sequencer.v ----
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pss_defs.vh"

// ****************************************
// program sequencer with stack and table read
// ****************************************
module pss_sequencer #(
  parameter PC_W = `PSS_PC_W
) (
  input  wire             hclk,
  input  wire             hresetn,
  // ahb-lite slave
  input  wire             hsel,
  input  wire [7:0]       haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire [31:0]      hwdata,
  input  wire             hready,
  output reg  [31:0]      hrdata,
  output reg              hreadyout,
  output reg              hresp,
  // decoder side, one-cycle pulses at instruction rate
  input  wire             cyc_en,
  input  wire             instr_exec,
  input  wire             jump_req,
  input  wire             call_req,
  input  wire [PC_W-1:0]  target_addr,
  input  wire             sub_return_req,
  input  wire             irq_return_req,
  input  wire             skip_req,
  input  wire             tbl_req,
  input  wire             tbl_last_page,
  input  wire             tbl_ext,
  input  wire [8:0]       tbl_dest,
  input  wire             irq_pending,
  input  wire [7:0]       alu_result,
  input  wire [8:0]       alu_dest,
  input  wire             alu_wr,
  input  wire [3:0]       alu_flags,
  // program memory
  output reg  [PC_W-1:0]  pmem_addr,
  input  wire [15:0]      pmem_data,
  // outputs to core
  output reg  [PC_W-1:0]  pc_out,
  output reg              dummy_cycle,
  output reg              irq_ack,
  output reg              dmem_wr,
  output reg  [8:0]       dmem_addr,
  output reg  [7:0]       dmem_wdata,
  output reg  [3:0]       status_flags,
  output reg              busy,
  // programming and debug pins
  input  wire             prog_clock_pin,
  input  wire             prog_data_pin_in,
  output reg              prog_data_pin_out,
  output reg              prog_data_pin_oe_n,
  input  wire             prog_mode,
  input  wire             debug_clock_pin,
  input  wire             debug_data_pin_in,
  output reg              debug_data_pin_out,
  output reg              debug_data_pin_oe_n,
  output reg  [15:0]      prog_shift_word,
  output reg              prog_word_valid
);
  localparam ST_RUN  = 2'd0;
  localparam ST_TBL2 = 2'd1;
  localparam ST_BR2  = 2'd2;

  // ****************************************
  // state
  // ****************************************
  reg [PC_W-1:0] pc_r;
  reg [1:0]      st_r;
  reg [7:0]      tblp_r;
  reg [7:0]      tbhp_r;
  reg [7:0]      tbl_hold_r;
  reg [PC_W-1:0] br_tgt_r;
  reg [8:0]      tbl_dst_r;
  reg            irq_held_r;
  reg            ovf_r;
  reg            pc_low_pend_r;
  reg [7:0]      pc_low_val_r;
  // bus data phase
  reg            dp_act_r;
  reg            dp_wr_r;
  reg [7:0]      dp_addr_r;

  wire           stk_full;
  wire           stk_empty;
  wire [3:0]     stk_level;
  wire [PC_W-1:0] stk_top;
  wire           stk_ovf;
  reg            push;
  reg            pop;
  reg [PC_W-1:0] push_val;

  // ****************************************
  // ahb-lite slave, zero wait states
  // ****************************************
  wire ap_valid = hsel && hready && (htrans == `PSS_HTRANS_NONSEQ);
  wire bus_wr   = dp_act_r && dp_wr_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_act_r  <= 1'b0;
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        dp_act_r  <= ap_valid;
        dp_wr_r   <= hwrite;
        dp_addr_r <= haddr;
      end
    end
  end

  // read data is registered in the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      case (haddr)
        `PSS_REG_PC_LOW:   hrdata <= {24'h00_0000, pc_r[7:0]};
        `PSS_REG_TBL_HOLD: hrdata <= {24'h00_0000, tbl_hold_r};
        `PSS_REG_TBLP: hrdata <= {24'h00_0000, tblp_r};
        `PSS_REG_TBHP: hrdata <= {24'h00_0000, tbhp_r};
        `PSS_REG_STAT: hrdata <= {24'h00_0000, ovf_r, (st_r != ST_RUN),
                                  irq_held_r, stk_full, stk_level};
        default:       hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // stack control and sequencing
  // ****************************************
  wire take_irq = cyc_en && st_r == ST_RUN && irq_pending && !stk_full;
  wire pc_low_apply = pc_low_pend_r && !(bus_wr && dp_addr_r == `PSS_REG_PC_LOW);

  // a pending pc low write owns the cycle unless an interrupt is taken; the dropped instruction must not move the stack
  always @* begin
    push     = 1'b0;
    pop      = 1'b0;
    push_val = pc_r;
    if (cyc_en && st_r == ST_RUN) begin
      if (take_irq || (instr_exec && call_req && !pc_low_apply)) begin
        push = 1'b1;
      end else if (instr_exec && !pc_low_apply && (sub_return_req || irq_return_req)) begin
        pop = 1'b1;
      end
    end
  end

  pss_return_stack #(
    .DEPTH (`PSS_STACK_DEPTH),
    .AW    (3),
    .DW    (PC_W)
  ) u_stack (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .push      (push),
    .pop       (pop),
    .push_data (push_val),
    .top_data  (stk_top),
    .full      (stk_full),
    .empty     (stk_empty),
    .level     (stk_level),
    .ovf_pulse (stk_ovf)
  );

  wire [PC_W-1:0] tbl_addr = tbl_last_page ?
                             {`PSS_LAST_PAGE, tblp_r} :
                             {tbhp_r[4:0], tblp_r};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_r          <= `PSS_RESET_VEC;
      st_r          <= ST_RUN;
      tblp_r        <= `PSS_TBL_RST;
      tbhp_r        <= `PSS_TBL_RST;
      tbl_hold_r    <= `PSS_TBL_RST;
      br_tgt_r      <= {PC_W{1'b0}};
      tbl_dst_r     <= 9'h000;
      irq_held_r    <= 1'b0;
      ovf_r         <= 1'b0;
      pc_low_pend_r <= 1'b0;
      pc_low_val_r  <= 8'h00;
      pc_out        <= `PSS_RESET_VEC;
      pmem_addr     <= `PSS_RESET_VEC;
      dummy_cycle   <= 1'b0;
      irq_ack       <= 1'b0;
      dmem_wr       <= 1'b0;
      dmem_addr     <= 9'h000;
      dmem_wdata    <= 8'h00;
      status_flags  <= 4'h0;
      busy          <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      dmem_wr <= 1'b0;
      if (stk_ovf) begin
        ovf_r <= 1'b1;
      end
      // bus writes; pc low byte takes effect at the next instruction edge
      if (bus_wr) begin
        case (dp_addr_r)
          `PSS_REG_PC_LOW: begin
            pc_low_pend_r <= 1'b1;
            pc_low_val_r  <= hwdata[7:0];
          end
          `PSS_REG_TBL_HOLD: tbl_hold_r <= hwdata[7:0];
          `PSS_REG_TBLP: tblp_r <= hwdata[7:0];
          `PSS_REG_TBHP: tbhp_r <= hwdata[7:0];
          `PSS_REG_STAT: if (hwdata[`PSS_ST_OVF] && !stk_ovf) ovf_r <= 1'b0;
          default: ;
        endcase
      end
      // set wins over acknowledge within the same cycle
      if (irq_pending && stk_full) begin
        irq_held_r <= 1'b1;
      end else if (take_irq) begin
        irq_held_r <= 1'b0;
      end
      if (alu_wr) begin
        dmem_wr      <= 1'b1;
        dmem_addr    <= alu_dest;
        dmem_wdata   <= alu_result;
        status_flags <= alu_flags;
      end
      // follows pc while running; a table issue below overrides it for the fetch
      if (st_r == ST_RUN) begin
        pmem_addr <= pc_r;
      end
      if (cyc_en) begin
        dummy_cycle <= 1'b0;
        case (st_r)
          ST_RUN: begin
            if (take_irq) begin
              irq_ack <= 1'b1;
              pc_r    <= target_addr;
            end else if (pc_low_apply) begin
              pc_r          <= {pc_r[PC_W-1:8], pc_low_val_r};
              pc_low_pend_r <= 1'b0;
              dummy_cycle   <= 1'b1;
            end else if (instr_exec) begin
              if (jump_req || call_req) begin
                br_tgt_r    <= target_addr;
                st_r        <= ST_BR2;
                busy        <= 1'b1;
                dummy_cycle <= 1'b1;
              end else if (sub_return_req || irq_return_req) begin
                pc_r        <= stk_top;
                dummy_cycle <= 1'b1;
              end else if (tbl_req) begin
                pmem_addr <= tbl_addr;
                tbl_dst_r <= tbl_ext ? tbl_dest : {1'b0, tbl_dest[7:0]};
                st_r      <= ST_TBL2;
                busy      <= 1'b1;
              end else if (skip_req) begin
                pc_r        <= pc_r + 1'b1;
                dummy_cycle <= 1'b1;
              end else begin
                pc_r <= pc_r + 1'b1;
              end
            end
          end
          ST_TBL2: begin
            dmem_wr    <= 1'b1;
            dmem_addr  <= tbl_dst_r;
            dmem_wdata <= pmem_data[7:0];
            tbl_hold_r <= pmem_data[15:8];
            pc_r       <= pc_r + 1'b1;
            st_r       <= ST_RUN;
            busy       <= 1'b0;
          end
          ST_BR2: begin
            pc_r <= br_tgt_r;
            st_r <= ST_RUN;
            busy <= 1'b0;
          end
          default: st_r <= ST_RUN;
        endcase
      end
      pc_out <= pc_r;
    end
  end

  // ****************************************
  // programming pin serial port
  // ****************************************
  // pins are asynchronous: three stages, edge accepted when stages 2 and 3 agree
  reg [2:0]  pck_s;
  reg [2:0]  pda_s;
  reg [2:0]  dck_s;
  reg        pck_q;
  reg [3:0]  bit_cnt_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pck_s <= 3'b000;
      pda_s <= 3'b000;
      dck_s <= 3'b000;
      pck_q <= 1'b0;
    end else begin
      pck_s <= {pck_s[1:0], prog_clock_pin};
      pda_s <= {pda_s[1:0], prog_data_pin_in};
      dck_s <= {dck_s[1:0], debug_clock_pin};
      if (pck_s[1] == pck_s[2]) begin
        pck_q <= pck_s[2];
      end
    end
  end

  wire pck_rise = pck_s[1] && pck_s[2] && !pck_q;

  // serial word in from the programmer; device only listens, never drives
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_shift_word     <= 16'h0000;
      prog_word_valid     <= 1'b0;
      bit_cnt_r           <= 4'h0;
      prog_data_pin_out   <= 1'b1;
      prog_data_pin_oe_n  <= 1'b1;
      debug_data_pin_out  <= 1'b1;
      debug_data_pin_oe_n <= 1'b1;
    end else begin
      prog_word_valid     <= 1'b0;
      prog_data_pin_oe_n  <= 1'b1;
      debug_data_pin_oe_n <= 1'b1;
      if (!prog_mode) begin
        bit_cnt_r <= 4'h0;
      end else if (pck_rise) begin
        prog_shift_word <= {pda_s[2], prog_shift_word[15:1]};
        bit_cnt_r       <= bit_cnt_r + 1'b1;
        if (bit_cnt_r == 4'hF) begin
          prog_word_valid <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- inc/pss_defs.vh ----
// Notes on behaviour
// - writing pc low byte jumps inside current 256-word page, upper bits kept
// - pc low byte write inserts one dummy cycle for prefetch
// - pc low byte readable and writable; higher pc bits not reachable
// - call or interrupt acknowledge pushes pc onto hardware return stack
// - subroutine or interrupt return pops top entry into pc
// - stack and pointer hidden from software, outside data and program space; stack level is readable in status bits 3:0
// - after reset stack pointer points at top of stack
// - full stack: interrupt flag recorded, acknowledge held until a return
// - call on full stack still executes, oldest saved pc lost
// - alu result written to destination, status flags updated
// - program memory 16 bits wide, addressed by pc, holds tables and vectors
// - reset starts execution at address 000h
// - table read fetches word at pointer pair, low byte to destination
// - table read loads upper word byte into table high-byte hold
// - table high-byte hold is software readable and writable
// - every table instruction takes exactly two cycles
// - last-page table reads use page 1f00h plus low pointer only
// - extended table reads perform same transfer for other sectors
// - programming transfers serially over one data pin clocked by programmer
// - debug uses one bidirectional data pin and one input clock pin; here the data pin is never driven and the clock pin is only synchronized, never used
// - pc is 13 bits: 5-bit high part and 8-bit low byte
// - pc increments per instruction except jumps, calls, interrupts, reset
// - taken skip discards prefetched instruction, inserts dummy cycle
// - branch and call take one extra cycle
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH

// ****************************************
// register map, word aligned byte offsets
// ****************************************
`define PSS_REG_PC_LOW     8'h00
`define PSS_REG_TBL_HOLD   8'h04
`define PSS_REG_TBLP       8'h08
`define PSS_REG_TBHP       8'h0C
`define PSS_REG_STAT       8'h10
`define PSS_REG_LAST       8'h14

// ****************************************
// widths, vectors, reset values
// ****************************************
`define PSS_PC_W           13
`define PSS_RESET_VEC      13'h0000
`define PSS_LAST_PAGE      5'h1F
`define PSS_STACK_DEPTH    8
`define PSS_TBL_RST        8'h00

// ****************************************
// status register fields
// ****************************************
`define PSS_ST_SP_LSB      0
`define PSS_ST_FULL        4
`define PSS_ST_IRQP        5
`define PSS_ST_DUMMY       6
`define PSS_ST_OVF         7

// ****************************************
// ahb codes
// ****************************************
`define PSS_HTRANS_NONSEQ  2'b10
`define PSS_HSIZE_WORD     3'b010

`endif

// ---- src/pss_ret_stack.v ----
`timescale 1ns/1ps
`include "pss_defs.vh"

// ****************************************
// hidden return stack
// ****************************************
module pss_return_stack #(
  parameter DEPTH = `PSS_STACK_DEPTH,
  parameter AW    = 3,
  parameter DW    = `PSS_PC_W
) (
  input  wire          hclk,
  input  wire          hresetn,
  input  wire          push,
  input  wire          pop,
  input  wire [DW-1:0] push_data,
  output wire [DW-1:0] top_data,
  output wire          full,
  output wire          empty,
  output wire [AW:0]   level,
  output reg           ovf_pulse
);
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW:0]   cnt_r;

  assign full     = (cnt_r == DEPTH[AW:0]);
  assign empty    = (cnt_r == {(AW+1){1'b0}});
  assign level    = cnt_r;
  assign top_data = mem[wp_r - 1'b1];

  // circular storage: overflow overwrites the oldest entry
  always @(posedge hclk) begin
    if (push) begin
      mem[wp_r] <= push_data;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_r      <= {AW{1'b0}};
      cnt_r     <= {(AW+1){1'b0}};
      ovf_pulse <= 1'b0;
    end else begin
      ovf_pulse <= 1'b0;
      if (push) begin
        wp_r <= wp_r + 1'b1;
        if (full) begin
          ovf_pulse <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end else if (pop && !empty) begin
        wp_r  <= wp_r - 1'b1;
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ---- dv/pss_pmem_model.sv ----
`timescale 1ns/1ps
// ****************************************
// program memory stand-in
// ****************************************
module pss_pmem_model (
  input  wire [12:0] pmem_addr,
  output wire [15:0] pmem_data
);
  // upper half from address bits 12:5, so the two bytes differ at the table addresses the test reads
  assign pmem_data = {pmem_addr[12:5], pmem_addr[7:0] ^ 8'hA5};
endmodule

// ---- dv/pss_seq_monitor.sv ----
`timescale 1ns/1ps
// ****************************************
// sequencer port checker
// ****************************************
module pss_seq_monitor (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire        hready,
  input wire [1:0]  htrans,
  input wire        hreadyout,
  input wire        hresp,
  input wire        cyc_en,
  input wire        instr_exec,
  input wire        jump_req,
  input wire        call_req,
  input wire        skip_req,
  input wire        tbl_req,
  input wire        irq_pending,
  input wire        irq_ack,
  input wire [7:0]  alu_result,
  input wire [8:0]  alu_dest,
  input wire        alu_wr,
  input wire [3:0]  alu_flags,
  input wire        dmem_wr,
  input wire [8:0]  dmem_addr,
  input wire [7:0]  dmem_wdata,
  input wire [3:0]  status_flags,
  input wire [12:0] pc_out,
  input wire        dummy_cycle,
  input wire        prog_data_pin_oe_n,
  input wire        debug_data_pin_oe_n
);
  default clocking mcb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_bus_take;
    hsel && hready && (htrans == 2'b10);
  endsequence
  sequence s_tbl_issue;
    cyc_en && instr_exec && tbl_req;
  endsequence
  sequence s_tbl_store;
    ##[1:2] dmem_wr;
  endsequence

  a_bus_zero_wait: assert property (s_bus_take |=> hreadyout && !hresp)
    else $error("bus answer late or not okay");
  a_table_two_cycles: assert property (s_tbl_issue |-> s_tbl_store)
    else $error("table store not in second cycle");
  a_branch_dummy: assert property (
    cyc_en && instr_exec && (call_req || jump_req) |-> ##[1:2] dummy_cycle)
    else $error("branch without dummy cycle");
  a_skip_dummy: assert property (cyc_en && instr_exec && skip_req |-> ##[1:2] dummy_cycle)
    else $error("skip without dummy cycle");
  a_alu_forward: assert property (alu_wr |=> dmem_wr && dmem_addr == $past(alu_dest)
    && dmem_wdata == $past(alu_result) && status_flags == $past(alu_flags))
    else $error("alu result not forwarded");
  a_reset_start: assert property ($rose(hresetn) |-> pc_out == 13'h0000)
    else $error("pc not at reset vector");
  a_ack_has_cause: assert property (irq_ack |-> $past(irq_pending))
    else $error("acknowledge without request");
  a_pins_released: assert property (prog_data_pin_oe_n && debug_data_pin_oe_n)
    else $error("device drives a tool pin");
endmodule

bind pss_sequencer pss_seq_monitor u_mon (
  .hclk, .hresetn, .hsel, .hready, .htrans, .hreadyout, .hresp, .cyc_en, .instr_exec,
  .jump_req, .call_req, .skip_req, .tbl_req, .irq_pending, .irq_ack, .alu_result, .alu_dest,
  .alu_wr, .alu_flags, .dmem_wr, .dmem_addr, .dmem_wdata, .status_flags, .pc_out,
  .dummy_cycle, .prog_data_pin_oe_n, .debug_data_pin_oe_n
);

// ---- dv/program_sequencer_stack_table_test.sv ----
`timescale 1ns/1ps
`include "pss_defs.vh"
module program_sequencer_stack_table_test;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cyc_en = 1'b1;
  logic        instr_exec = 1'b0, tbl_last_page = 1'b0, tbl_ext = 1'b0, irq_pending = 1'b0;
  logic        alu_wr = 1'b0, prog_clock_pin = 1'b0, prog_data_pin_in = 1'b0, prog_mode = 1'b0;
  logic [5:0]  req = 6'h00;
  logic [7:0]  haddr = 8'h00, alu_result = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = `PSS_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [12:0] target_addr = 13'h0000, a;
  logic [8:0]  tbl_dest = 9'h000, alu_dest = 9'h000;
  logic [3:0]  alu_flags = 4'h0;
  logic [15:0] got_word = 16'h0000, ser_word = 16'hC3A5;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, dummy_cycle, irq_ack, dmem_wr, prog_word_valid, busy;
  wire  [12:0] pmem_addr, pc_out;
  wire  [15:0] pmem_data, prog_shift_word;
  wire  [8:0]  dmem_addr;
  wire  [7:0]  dmem_wdata;
  wire  [3:0]  status_flags;
  int          mismatches = 0, samples_checked = 0, ack_cnt = 0, dummy_cnt = 0, word_cnt = 0;
  int          i, n, d0, busy_cnt = 0;

  pss_sequencer uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .cyc_en, .instr_exec, .jump_req(req[5]), .call_req(req[4]),
    .target_addr, .sub_return_req(req[3]), .irq_return_req(req[2]), .skip_req(req[1]),
    .tbl_req(req[0]),
    .tbl_last_page, .tbl_ext, .tbl_dest, .irq_pending, .alu_result, .alu_dest, .alu_wr,
    .alu_flags, .pmem_addr, .pmem_data, .pc_out, .dummy_cycle, .irq_ack, .dmem_wr, .dmem_addr,
    .dmem_wdata, .status_flags, .busy, .prog_clock_pin, .prog_data_pin_in,
    .prog_data_pin_out(), .prog_data_pin_oe_n(), .prog_mode, .debug_clock_pin(1'b0),
    .debug_data_pin_in(1'b0), .debug_data_pin_out(), .debug_data_pin_oe_n(),
    .prog_shift_word, .prog_word_valid
  );
  pss_pmem_model u_pmem (.pmem_addr, .pmem_data);

  always #20 hclk = ~hclk;

  // interrupt logic drops its request once acknowledged
  always @(posedge hclk) begin
    if (irq_ack === 1'b1) begin
      ack_cnt <= ack_cnt + 1;
      irq_pending <= 1'b0;
    end
    if (dummy_cycle === 1'b1) dummy_cnt <= dummy_cnt + 1;
    if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
    if (prog_word_valid === 1'b1) begin
      word_cnt <= word_cnt + 1;
      got_word <= prog_shift_word;
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    chk_bus({16'h0000, got}, {16'h0000, exp});
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge hclk);
  endtask
  task automatic bus_xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                          output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= `PSS_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic reg_wr(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] rd;
    bus_xfer(1'b1, ad, wd, rd);
  endtask
  task automatic reg_rd(input logic [7:0] ad, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] rd;
    bus_xfer(1'b0, ad, 32'h0000_0000, rd);
    chk_bus(rd & m, exp);
  endtask
  // one instruction, held for exactly one edge
  task automatic issue(input logic [5:0] k, input logic [12:0] t, input int k_idle);
    req <= k;
    target_addr <= t;
    instr_exec <= 1'b1;
    @(posedge hclk);
    req <= 6'h00;
    instr_exec <= 1'b0;
    idle(k_idle);
  endtask
  function automatic logic [12:0] tg(input int k);
    return 13'(k * 257);
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    idle(10);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_out({3'b000, pc_out}, 16'h0000);
    reg_rd(`PSS_REG_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
    reg_rd(8'h18, 32'h0000_0000, 32'hFFFF_FFFF);
    repeat (3) issue(6'h00, 13'h0000, 1);
    idle(4);
    chk_out({3'b000, pc_out}, 16'h0003);
    d0 = dummy_cnt;
    issue(6'h20, 13'h1234, 6);
    chk_out({3'b000, pc_out}, 16'h1234);
    reg_wr(`PSS_REG_PC_LOW, 32'h0000_005A);
    idle(5);
    chk_out({3'b000, pc_out}, 16'h125A);
    chk_out(16'(dummy_cnt - d0), 16'h0002);
    reg_rd(`PSS_REG_PC_LOW, 32'h0000_005A, 32'hFFFF_FFFF);
    reg_wr(`PSS_REG_TBL_HOLD, 32'h0000_003C);
    reg_rd(`PSS_REG_TBL_HOLD, 32'h0000_003C, 32'hFFFF_FFFF);
    d0 = dummy_cnt;
    issue(6'h02, 13'h0000, 5);
    chk_out(16'(dummy_cnt - d0), 16'h0001);
    for (i = 1; i <= 8; i++) issue(6'h10, tg(i), 5);
    reg_rd(`PSS_REG_STAT, 32'h0000_0018, 32'h0000_001F);
    irq_pending <= 1'b1;
    idle(6);
    chk_out(16'(ack_cnt), 16'h0000);
    reg_rd(`PSS_REG_STAT, 32'h0000_0038, 32'h0000_003F);
    issue(6'h10, tg(9), 5);
    chk_out({3'b000, pc_out}, {3'b000, tg(9)});
    reg_rd(`PSS_REG_STAT, 32'h0000_00B8, 32'h0000_00BF);
    issue(6'h08, 13'h0004, 10);
    chk_out(16'(ack_cnt), 16'h0001);
    chk_out({3'b000, pc_out}, 16'h0004);
    issue(6'h04, 13'h0004, 5);
    chk_out({3'b000, pc_out}, {3'b000, tg(8)});
    for (i = 7; i >= 1; i--) begin
      issue(6'h08, 13'h0004, 5);
      chk_out({3'b000, pc_out}, {3'b000, tg(i)});
    end
    reg_rd(`PSS_REG_STAT, 32'h0000_0080, 32'h0000_009F);
    reg_wr(`PSS_REG_TBLP, 32'h0000_0034);
    reg_wr(`PSS_REG_TBHP, 32'h0000_000A);
    for (i = 0; i < 3; i++) begin
      a = (i == 1) ? 13'h1F34 : 13'h0A34;
      tbl_dest <= (i == 2) ? 9'h185 : ((i == 1) ? 9'h0C6 : 9'h085);
      tbl_last_page <= (i == 1);
      tbl_ext <= (i == 2);
      d0 = busy_cnt;
      issue(6'h01, 13'h0000, 0);
      for (n = 0; n < 8 && dmem_wr !== 1'b1; n++) @(posedge hclk);
      chk_out({7'h00, dmem_addr}, {7'h00, tbl_dest});
      chk_out({8'h00, dmem_wdata}, {8'h00, a[7:0] ^ 8'hA5});
      chk_out(16'(busy_cnt - d0), 16'h0001);
      idle(3);
      reg_rd(`PSS_REG_TBL_HOLD, {24'h00_0000, a[12:5]}, 32'h0000_00FF);
    end
    alu_result <= 8'h77;
    alu_dest <= 9'h1A3;
    alu_flags <= 4'hA;
    alu_wr <= 1'b1;
    @(posedge hclk);
    alu_wr <= 1'b0;
    @(posedge hclk);
    chk_out({dmem_wr, dmem_addr, 2'b00, status_flags}, {1'b1, 9'h1A3, 2'b00, 4'hA});
    chk_out({8'h00, dmem_wdata}, 16'h0077);
    prog_mode <= 1'b1;
    // only the programmer drives the data and clock pins
    for (i = 0; i < 16; i++) begin
      prog_data_pin_in <= ser_word[i];
      idle(3);
      prog_clock_pin <= 1'b1;
      idle(3);
      prog_clock_pin <= 1'b0;
    end
    idle(8);
    chk_out(16'(word_cnt), 16'h0001);
    chk_out(got_word, 16'hC3A5);
    tally_and_finish();
  end

  initial begin
    idle(8000);
    mismatches++;
    tally_and_finish();
  end
endmodule
